//--- t8w_pkg.sv
`default_nettype none
package t8w_pkg;

  // register indices on the plain register port
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_COUNT   = 8'h01;
  localparam logic [7:0] REG_COMPARE = 8'h02;
  localparam logic [7:0] REG_FLAGS   = 8'h03;
  localparam logic [7:0] REG_PORT    = 8'h04;

  // control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_ACT_LSB   = 2;
  localparam int CTRL_CS_LSB    = 4;
  localparam int CTRL_FORCE_BIT = 7;

  // flag register fields, write one to clear
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;

  // port register fields
  localparam int PORT_DIR_BIT  = 0;
  localparam int PORT_DATA_BIT = 1;

  // wave mode select encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE  = 2'h1;
  localparam logic [1:0] MODE_CTC    = 2'h2;
  localparam logic [1:0] MODE_FAST   = 2'h3;

  // compare output action encodings
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // clock select encodings
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;

  // counter extremes and step, reset values and prescaler width
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RST_FIELD2 = 2'h0;
  localparam logic [2:0] RST_FIELD3 = 3'h0;
  localparam int         PRE_W      = 10;

endpackage
`default_nettype wire

//--- t8w_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module t8w_prescaler
  import t8w_pkg::*;
#(
  parameter int WIDTH = PRE_W
) (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_clk_en,
  // select and tick
  input  wire logic [2:0] i_select,
  output logic            o_tick
);

  logic [WIDTH-1:0] div_count;

  // free running so that a select change takes effect without a restart
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      div_count <= '0;
    end else if (i_clk_en) begin
      div_count <= div_count + 1'b1;
    end
  end

  // tick is a one-cycle enable, never a clock
  always_comb begin
    o_tick = 1'b0;
    if (i_clk_en) begin
      case (i_select)
        CS_DIV1:    o_tick = 1'b1;
        CS_DIV8:    o_tick = &div_count[2:0];
        CS_DIV64:   o_tick = &div_count[5:0];
        CS_DIV256:  o_tick = &div_count[7:0];
        CS_DIV1024: o_tick = &div_count[9:0];
        default:    o_tick = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- t8w_cmp_buf.sv
`timescale 1ns/1ps
`default_nettype none
module t8w_cmp_buf
  import t8w_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic             i_clk_en,
  // software side
  input  wire logic             i_write,
  input  wire logic [WIDTH-1:0] i_wdata,
  // buffering control
  input  wire logic             i_buffered,
  input  wire logic             i_load,
  // values
  output logic      [WIDTH-1:0] o_active,
  output logic      [WIDTH-1:0] o_buffer
);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_buffer <= '0;
    end else if (i_clk_en && i_write) begin
      o_buffer <= i_wdata;
    end
  end

  // a load in the write cycle takes the old buffer, the new one waits a period
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_active <= '0;
    end else if (i_clk_en) begin
      if (i_write && !i_buffered) begin
        o_active <= i_wdata;
      end else if (i_load && i_buffered) begin
        o_active <= o_buffer;
      end
    end
  end

endmodule
`default_nettype wire

//--- t8w_timer.sv
`timescale 1ns/1ps
`default_nettype none
module t8w_timer
  import t8w_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_nrst,
  input  wire logic              i_clk_en,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  // pin
  output logic                   o_pin_out,
  output logic                   o_pin_oe,
  // status view
  output logic                   o_wave_output,
  output logic                   o_overflow_flag,
  output logic                   o_compare_flag,
  output logic      [7:0]        o_counter_value,
  output logic                   o_timer_tick
);

  // settings
  logic [1:0] wave_mode_select;
  logic [1:0] compare_output_action;
  logic [2:0] clock_select;
  logic       pin_dir;
  logic       port_data;

  // timer state
  logic [7:0] counter_value;
  logic       count_up;
  logic       wave_output;
  logic       overflow_flag;
  logic       compare_flag;
  logic       match_block;

  // derived
  logic       timer_tick;
  logic [7:0] compare_value;
  logic [7:0] compare_buffer;
  logic       pwm_mode;
  logic       at_max;
  logic       eff_up;
  logic       raw_match;
  logic       match;
  logic       top_ignore;
  logic       load_top;
  logic       ovf_event;
  logic       force_strobe;
  logic [1:0] force_action;
  logic [7:0] next_counter;
  logic       next_count_up;
  logic       next_wave;
  logic [7:0] next_rdata;

  // address decode
  logic [7:0] addr8;
  logic       ctrl_wr;
  logic       count_wr;
  logic       cmp_wr;
  logic       flag_wr;
  logic       port_wr;

  assign addr8 = i_addr[7:0];

  always_comb begin
    ctrl_wr  = 1'b0;
    count_wr = 1'b0;
    cmp_wr   = 1'b0;
    flag_wr  = 1'b0;
    port_wr  = 1'b0;
    if (i_wr && addr8 == REG_CTRL) begin
      ctrl_wr = 1'b1;
    end else if (i_wr && addr8 == REG_COUNT) begin
      count_wr = 1'b1;
    end else if (i_wr && addr8 == REG_COMPARE) begin
      cmp_wr = 1'b1;
    end else if (i_wr && addr8 == REG_FLAGS) begin
      flag_wr = 1'b1;
    end else if (i_wr && addr8 == REG_PORT) begin
      port_wr = 1'b1;
    end
  end

  // prescaler gives the timer tick as an enable on the one clock
  t8w_prescaler #(
    .WIDTH (PRE_W)
  ) u_prescaler (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_clk_en (i_clk_en),
    .i_select (clock_select),
    .o_tick   (timer_tick)
  );

  assign pwm_mode = wave_mode_select[0];
  assign at_max   = counter_value == CNT_MAX;
  assign load_top = timer_tick && pwm_mode && at_max;

  t8w_cmp_buf #(
    .WIDTH (8)
  ) u_cmp_buf (
    .i_clock    (i_clock),
    .i_nrst     (i_nrst),
    .i_clk_en   (i_clk_en),
    .i_write    (cmp_wr),
    .i_wdata    (i_wdata),
    .i_buffered (pwm_mode),
    .i_load     (load_top),
    .o_active   (compare_value),
    .o_buffer   (compare_buffer)
  );

  // control register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wave_mode_select      <= RST_FIELD2;
      compare_output_action <= RST_FIELD2;
      clock_select          <= RST_FIELD3;
    end else if (i_clk_en && ctrl_wr) begin
      wave_mode_select      <= i_wdata[CTRL_MODE_LSB +: 2];
      compare_output_action <= i_wdata[CTRL_ACT_LSB +: 2];
      clock_select          <= i_wdata[CTRL_CS_LSB +: 3];
    end
  end

  // force applies the action being written when the mode written is normal or CTC, so software need not write twice
  assign force_strobe = i_clk_en && ctrl_wr && i_wdata[CTRL_FORCE_BIT] && !i_wdata[CTRL_MODE_LSB];
  assign force_action = i_wdata[CTRL_ACT_LSB +: 2];

  // port register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_dir   <= 1'b0;
      port_data <= 1'b0;
    end else if (i_clk_en && port_wr) begin
      pin_dir   <= i_wdata[PORT_DIR_BIT];
      port_data <= i_wdata[PORT_DATA_BIT];
    end
  end

  // effective direction: bottom always turns up, max always turns down
  always_comb begin
    if (counter_value == CNT_BOTTOM) begin
      eff_up = 1'b1;
    end else if (at_max) begin
      eff_up = 1'b0;
    end else begin
      eff_up = count_up;
    end
  end

  // a counter write hides the match for one tick
  assign raw_match  = counter_value == compare_value;
  assign match      = raw_match && !match_block;
  assign top_ignore = pwm_mode && compare_value == CNT_MAX && compare_output_action[1];

  // counting sequence per mode
  always_comb begin
    next_counter  = counter_value;
    next_count_up = count_up;
    case (wave_mode_select)
      MODE_PHASE: begin
        if (eff_up) begin
          next_counter  = counter_value + CNT_ONE;
          next_count_up = 1'b1;
        end else begin
          next_counter  = counter_value - CNT_ONE;
          next_count_up = 1'b0;
        end
      end
      MODE_CTC: begin
        if (match) begin
          next_counter = CNT_BOTTOM;
        end else begin
          next_counter = counter_value + CNT_ONE;
        end
      end
      MODE_FAST: begin
        next_counter = counter_value + CNT_ONE;
      end
      default: begin
        next_counter = counter_value + CNT_ONE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      counter_value <= RST_BYTE;
      count_up      <= 1'b1;
    end else if (i_clk_en) begin
      if (count_wr) begin
        counter_value <= i_wdata;
      end else if (timer_tick) begin
        counter_value <= next_counter;
        count_up      <= next_count_up;
      end
    end
  end

  // block persists while stopped and ends at the first tick after the write
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      match_block <= 1'b0;
    end else if (i_clk_en) begin
      if (count_wr) begin
        match_block <= 1'b1;
      end else if (timer_tick) begin
        match_block <= 1'b0;
      end
    end
  end

  // overflow: at max except in phase mode, where it is the arrival at bottom
  always_comb begin
    if (wave_mode_select == MODE_PHASE) begin
      ovf_event = !eff_up && next_counter == CNT_BOTTOM;
    end else begin
      ovf_event = at_max;
    end
  end

  // flags: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      overflow_flag <= 1'b0;
    end else if (i_clk_en) begin
      if (timer_tick && ovf_event) begin
        overflow_flag <= 1'b1;
      end else if (flag_wr && i_wdata[FLAG_OVF_BIT]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      compare_flag <= 1'b0;
    end else if (i_clk_en) begin
      if (timer_tick && match) begin
        compare_flag <= 1'b1;
      end else if (flag_wr && i_wdata[FLAG_CMP_BIT]) begin
        compare_flag <= 1'b0;
      end
    end
  end

  // wave output state
  always_comb begin
    next_wave = wave_output;
    if (timer_tick) begin
      case (wave_mode_select)
        MODE_FAST: begin
          if (match && !top_ignore) begin
            case (compare_output_action)
              ACT_TOGGLE: next_wave = !wave_output;
              ACT_CLEAR:  next_wave = 1'b0;
              ACT_SET:    next_wave = 1'b1;
              default:    next_wave = wave_output;
            endcase
          end
          // bottom action follows the match so a zero compare leaves a spike
          if (at_max && compare_output_action == ACT_CLEAR) begin
            next_wave = 1'b1;
          end else if (at_max && compare_output_action == ACT_SET) begin
            next_wave = 1'b0;
          end
        end
        MODE_PHASE: begin
          if (match && !top_ignore && compare_output_action == ACT_CLEAR) begin
            next_wave = !eff_up;
          end else if (match && !top_ignore && compare_output_action == ACT_SET) begin
            next_wave = eff_up;
          end else if (at_max && top_ignore) begin
            next_wave = compare_output_action == ACT_CLEAR;
          end
        end
        default: begin
          if (match) begin
            case (compare_output_action)
              ACT_TOGGLE: next_wave = !wave_output;
              ACT_CLEAR:  next_wave = 1'b0;
              ACT_SET:    next_wave = 1'b1;
              default:    next_wave = wave_output;
            endcase
          end
        end
      endcase
    end
    if (force_strobe) begin
      case (force_action)
        ACT_TOGGLE: next_wave = !wave_output;
        ACT_CLEAR:  next_wave = 1'b0;
        ACT_SET:    next_wave = 1'b1;
        default:    next_wave = wave_output;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wave_output <= 1'b0;
    end else if (i_clk_en) begin
      wave_output <= next_wave;
    end
  end

  // pin: override only when an action is selected, drive only as output
  assign o_pin_out = (compare_output_action != ACT_OFF) ? wave_output : port_data;
  assign o_pin_oe  = pin_dir;

  // read mux; data stand only in the cycle after the strobe
  always_comb begin
    next_rdata = RST_BYTE;
    if (addr8 == REG_CTRL) begin
      next_rdata = {1'b0, clock_select, compare_output_action, wave_mode_select};
    end else if (addr8 == REG_COUNT) begin
      next_rdata = counter_value;
    end else if (addr8 == REG_COMPARE) begin
      next_rdata = compare_buffer;
    end else if (addr8 == REG_FLAGS) begin
      next_rdata = {6'h00, compare_flag, overflow_flag};
    end else if (addr8 == REG_PORT) begin
      next_rdata = {6'h00, port_data, pin_dir};
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= RST_BYTE;
    end else if (i_clk_en) begin
      o_rdata <= i_rd ? next_rdata : RST_BYTE;
    end
  end

  assign o_wave_output   = wave_output;
  assign o_overflow_flag = overflow_flag;
  assign o_compare_flag  = compare_flag;
  assign o_counter_value = counter_value;
  assign o_timer_tick    = timer_tick;

endmodule
`default_nettype wire

//--- t8w_load.sv
`timescale 1ns/1ps
`default_nettype none
module t8w_load (
  // pin side
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe,
  // level seen by the load
  output logic      o_level
);
  // a pull-down holds the line low whenever the pin is not driven
  assign o_level = i_pin_oe ? i_pin_out : 1'b0;
endmodule
`default_nettype wire

//--- t8w_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module t8w_monitor
  import t8w_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              i_clock,
  input wire logic              i_nrst,
  input wire logic              i_clk_en,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0]        i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [7:0]        o_rdata,
  // pin and status
  input wire logic              o_pin_out,
  input wire logic              o_pin_oe,
  input wire logic              o_wave_output,
  input wire logic              o_overflow_flag,
  input wire logic              o_compare_flag,
  input wire logic [7:0]        o_counter_value,
  input wire logic              o_timer_tick
);
  logic [1:0] mode;
  logic [1:0] act;
  logic [7:0] cmp;
  logic [7:0] prev;
  logic       pdata;
  logic       blk;
  logic       wr_ok;
  logic       tk;
  logic       ctc_match;
  assign wr_ok = i_wr && i_clk_en;
  // ticks with any write at the same edge are left out: a counter write wins there
  assign tk = o_timer_tick && i_clk_en && !wr_ok;
  assign ctc_match = tk && mode == MODE_CTC && o_counter_value == cmp && !blk;
  // shadow of the settings; only valid while compare is written after the mode
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mode <= MODE_NORMAL;
      act <= ACT_OFF;
      cmp <= RST_BYTE;
      pdata <= 1'b0;
      blk <= 1'b0;
    end else begin
      if (wr_ok && i_addr == ADDR_W'(REG_CTRL)) begin
        mode <= i_wdata[1:0];
        act <= i_wdata[3:2];
      end
      if (wr_ok && i_addr == ADDR_W'(REG_COMPARE)) begin
        cmp <= i_wdata;
      end
      if (wr_ok && i_addr == ADDR_W'(REG_PORT)) begin
        pdata <= i_wdata[PORT_DATA_BIT];
      end
      if (wr_ok && i_addr == ADDR_W'(REG_COUNT)) begin
        blk <= 1'b1;
      end else if (o_timer_tick && i_clk_en) begin
        blk <= 1'b0;
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      prev <= RST_BYTE;
    end else if (tk) begin
      prev <= o_counter_value;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  ctc_clear_a : assert property (ctc_match |=> o_counter_value == CNT_BOTTOM)
    else $error("counter not cleared at compare top");
  cmp_flag_a : assert property (ctc_match |=> o_compare_flag)
    else $error("compare flag missing after match");
  ctc_toggle_a : assert property (ctc_match && act == ACT_TOGGLE |=> o_wave_output != $past(o_wave_output))
    else $error("wave output did not toggle on match");
  pin_wave_a : assert property (act != ACT_OFF |-> o_pin_out == o_wave_output)
    else $error("pin does not carry wave output");
  pin_port_a : assert property (act == ACT_OFF |-> o_pin_out == pdata)
    else $error("pin does not carry port data");
  count_hold_a : assert property (!o_timer_tick && !wr_ok |=> $stable(o_counter_value))
    else $error("counter moved without a tick");
  fast_wrap_a : assert property (tk && mode == MODE_FAST && o_counter_value == CNT_MAX
    |=> o_counter_value == CNT_BOTTOM && o_overflow_flag)
    else $error("fast wrap or overflow wrong");
  fast_bottom_a : assert property (tk && mode == MODE_FAST && o_counter_value == CNT_MAX && act[1]
    |=> o_wave_output == (act == ACT_CLEAR))
    else $error("fast bottom action wrong");
  phase_turn_a : assert property (tk && mode == MODE_PHASE && o_counter_value == CNT_MAX
    |=> o_counter_value == 8'hfe)
    else $error("phase counter did not turn after one tick at max");
  phase_ovf_a : assert property (tk && mode == MODE_PHASE && o_counter_value == CNT_ONE && prev == 8'h02
    |=> o_counter_value == CNT_BOTTOM && o_overflow_flag)
    else $error("phase overflow flag missing at bottom");
  ctc_hit_c : cover property (ctc_match);
  fast_wrap_c : cover property (tk && mode == MODE_FAST && o_counter_value == CNT_MAX);
  phase_turn_c : cover property (tk && mode == MODE_PHASE && o_counter_value == CNT_MAX);
endmodule
bind t8w_timer t8w_monitor #(.ADDR_W(ADDR_W)) u_monitor (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_wave_output(o_wave_output),
  .o_overflow_flag(o_overflow_flag), .o_compare_flag(o_compare_flag),
  .o_counter_value(o_counter_value), .o_timer_tick(o_timer_tick)
);
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import t8w_pkg::*;;
  logic       i_clock;
  logic       i_nrst;
  logic       i_clk_en;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  logic       o_pin_out;
  logic       o_pin_oe;
  logic       o_wave_output;
  logic       o_overflow_flag;
  logic       o_compare_flag;
  logic [7:0] o_counter_value;
  logic       o_timer_tick;
  logic       lvl_pin;
  logic [7:0] rv;
  int         err_count;
  int         cmp_count;
  int         hi;
  int         per;
  t8w_timer DUT (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_wave_output(o_wave_output),
    .o_overflow_flag(o_overflow_flag), .o_compare_flag(o_compare_flag),
    .o_counter_value(o_counter_value), .o_timer_tick(o_timer_tick)
  );
  t8w_load u_load (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .o_level(lvl_pin));
  initial i_clock = 1'b0;
  always #20 i_clock = ~i_clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // one idle cycle after each strobe keeps every strobe a single-cycle pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    d = o_rdata;
    @(posedge i_clock);
  endtask
  task automatic until_lvl(input logic lvl, output int n);
    n = 0;
    while (lvl_pin !== lvl && n < 5000) begin
      @(negedge i_clock);
      n++;
    end
  endtask
  // syncs to a rising pin edge, then counts high time and full period
  task automatic measure(output int h, output int p);
    int lo;
    until_lvl(1'b0, h);
    until_lvl(1'b1, h);
    until_lvl(1'b0, h);
    until_lvl(1'b1, lo);
    p = h + lo;
    @(posedge i_clock);
  endtask
  task automatic steady(input logic exp);
    int bad;
    bad = 0;
    repeat (600) @(posedge i_clock);
    repeat (520) begin
      @(negedge i_clock);
      if (lvl_pin !== exp) bad++;
    end
    check(bad, 0);
    @(posedge i_clock);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(60000 * 40);
    err_count++;
    final_report();
  end
  initial begin
    err_count = 0;
    cmp_count = 0;
    i_nrst = 1'b0;
    i_clk_en = 1'b1;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (10) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    check({o_wave_output, o_pin_oe, o_overflow_flag, o_compare_flag, o_counter_value}, 32'h0000_0000);
    for (int a = 0; a < 5; a++) begin
      rd(8'(a), rv);
      check(rv, 8'h00);
    end
    rd(8'h10, rv);
    check(rv, 8'h00);
    // clear-on-compare, match blocked by a counter write while stopped
    wr(REG_PORT, 8'h01);
    wr(REG_CTRL, 8'h06);
    // force strobe with the toggle action while stopped moves the wave state
    wr(REG_CTRL, 8'h86);
    check(o_wave_output, 1'b1);
    wr(REG_COMPARE, 8'h05);
    wr(REG_COUNT, 8'h05);
    wr(REG_CTRL, 8'h16);
    // the counter moves at the edge that ends the write task, so look mid-cycle
    @(negedge i_clock);
    check(o_compare_flag, 1'b0);
    check(o_counter_value > 8'h05, 1'b1);
    hi = 0;
    while (o_counter_value !== 8'h00 && hi < 400) begin
      @(negedge i_clock);
      hi++;
    end
    check(o_overflow_flag, 1'b1);
    check(o_compare_flag, 1'b0);
    measure(hi, per);
    check(hi, 6);
    check(per, 12);
    check(o_compare_flag, 1'b1);
    rd(REG_COMPARE, rv);
    check(rv, 8'h05);
    rd(REG_FLAGS, rv);
    check(rv, 8'h03);
    // overflow cannot return while the count tops out at five
    wr(REG_FLAGS, 8'h01);
    rd(REG_FLAGS, rv);
    check(rv, 8'h02);
    wr(REG_PORT, 8'h00);
    steady(1'b0);
    wr(REG_CTRL, 8'h12);
    wr(REG_PORT, 8'h03);
    steady(1'b1);
    // fast mode, non-inverted, then a buffered compare change mid-period
    wr(REG_PORT, 8'h01);
    wr(REG_CTRL, 8'h1b);
    wr(REG_COMPARE, 8'h40);
    measure(hi, per);
    check(hi, 65);
    check(per, 256);
    while (o_counter_value !== 8'h0a && hi < 2000) begin
      @(posedge i_clock);
      hi++;
    end
    wr(REG_COMPARE, 8'h80);
    until_lvl(1'b0, hi);
    check(o_counter_value, 8'h41);
    @(posedge i_clock);
    measure(hi, per);
    check(hi, 129);
    wr(REG_CTRL, 8'h1f);
    measure(hi, per);
    check(hi, 127);
    wr(REG_CTRL, 8'h17);
    measure(hi, per);
    check(hi, 256);
    check(per, 512);
    wr(REG_CTRL, 8'h1b);
    wr(REG_COMPARE, 8'h00);
    measure(hi, per);
    check(hi, 1);
    check(per, 256);
    wr(REG_COMPARE, 8'hff);
    steady(1'b1);
    wr(REG_CTRL, 8'h1f);
    steady(1'b0);
    // prescaled ticks stretch the same waveform eightfold
    wr(REG_CTRL, 8'h2b);
    wr(REG_COMPARE, 8'h40);
    measure(hi, per);
    check(hi, 520);
    check(per, 2048);
    // phase correct mode
    wr(REG_CTRL, 8'h19);
    wr(REG_COMPARE, 8'h64);
    measure(hi, per);
    check(hi, 200);
    check(per, 510);
    wr(REG_CTRL, 8'h1d);
    measure(hi, per);
    check(hi, 310);
    wr(REG_CTRL, 8'h19);
    wr(REG_COMPARE, 8'h00);
    steady(1'b0);
    wr(REG_COMPARE, 8'hff);
    steady(1'b1);
    wr(REG_CTRL, 8'h1d);
    steady(1'b0);
    final_report();
  end
endmodule
`default_nettype wire
